// ### nv_array.sv
// Flip-flop storage for the data EEPROM and the flash program array
`timescale 1ns/100ps
module nv_array import nv_pkg::*; #(
	parameter int EE_AW    = 8,
	parameter int FL_BITS  = FL_AW,
	parameter int BLK_BITS = 3
) (
	input  wire logic                                 mclk,
	input  wire logic                                 ce,
	input  wire logic [EE_AW-1:0]                     ee_addr,
	output logic [7:0]                                ee_rdata,
	input  wire logic                                 ee_we,
	input  wire logic [EE_AW-1:0]                     ee_waddr,
	input  wire logic [7:0]                           ee_wdata,
	input  wire logic [FL_BITS-1:0]                   fl_addr,
	output logic [WORD_W-1:0]                         fl_rdata,
	input  wire logic                                 fl_commit,
	input  wire logic [FL_BITS-1:0]                   fl_base,
	input  wire logic [(1<<BLK_BITS)-1:0][WORD_W-1:0] fl_buf
);

	logic [7:0]        ee_mem [1<<EE_AW];
	logic [WORD_W-1:0] fl_mem [1<<FL_BITS];

	// ----------------------------------------------------------------
	// Read ports
	// ----------------------------------------------------------------
	assign ee_rdata = ee_mem[ee_addr];
	assign fl_rdata = fl_mem[fl_addr];

	// Byte store at the end of the write time
	always_ff @(posedge mclk) begin
		if (ce && ee_we) begin
			ee_mem[ee_waddr] <= ee_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Per-word erase and program
	// ----------------------------------------------------------------
	// erase then program: whole aligned erase group is wiped, the
	// buffered block inside it is programmed, nothing crosses a boundary
	for (genvar g = 0; g < (1 << FL_BITS); g++) begin : g_word
		localparam logic [FL_BITS-1:0] IDX = FL_BITS'(g);
		wire in_erase = IDX[FL_BITS-1:ERASE_BITS] == fl_base[FL_BITS-1:ERASE_BITS];
		wire in_block = IDX[FL_BITS-1:BLK_BITS] == fl_base[FL_BITS-1:BLK_BITS];
		always_ff @(posedge mclk) begin
			if (ce && fl_commit && in_erase) begin
				fl_mem[g] <= in_block ? fl_buf[IDX[BLK_BITS-1:0]] : ERASED_WORD;
			end
		end
	end

endmodule

// ### nv_ctrl.sv
// Self-programming controller for data EEPROM writes and flash read and write
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

// Summary of operation
// - Start needs 55h then AAh unlock writes
// - Start refused while write enable clear
// - Write enable changed only by software
// - Started write finishes despite enable cleared
// - EEPROM completion clears start, sets done
// - Flash read ignores second following instruction
// - Read data held until replaced
// - Refused flash start drops back, no operation
// - Protected flash segment never written
// - Flash blocks are aligned eight words
// - Sixteen-word erase, then eight-word program
// - Each word loads buffer, last word commits
// - Two setup cycles after flash start
// - CPU stalls only during final erase and program
// - Execution resumes at third instruction after
// - EEPROM read data ready next cycle
// - Reset during write sets abort flag
// - Enable clear and writes blocked at power-up
module nv_ctrl import nv_pkg::*; #(
	parameter int ERASE_CYCLES      = ERASE_CYCLES_DEF,
	parameter int PWRT_CYCLES       = PWRT_CYCLES_DEF,
	parameter int EE_WRITE_CYCLES   = 1000,
	parameter int FLASH_PROG_CYCLES = 1000,
	parameter int BLK_BITS          = 3,
	parameter bit SELF_WRITE_EN     = 1'b1
) (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire logic              ce,
	input  wire logic              warm_rst,
	input  wire logic [1:0]        block_protect_cfg,
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_we,
	input  wire logic              reg_re,
	output logic [7:0]             reg_rdata,
	output logic                   cpu_stall,
	output logic                   insn_squash,
	output logic                   nv_done_flag
);

	localparam int BLK = 1 << BLK_BITS;
	localparam int PW  = $clog2(PWRT_CYCLES + 1);
	localparam int CW  = $clog2(ERASE_CYCLES + FLASH_PROG_CYCLES + EE_WRITE_CYCLES + 1);

	ctl_t                         ctl_r, ctl_nxt;
	unl_t                         unl_r, unl_nxt;
	op_t                          op_r, op_nxt;
	logic [CW-1:0]                cnt_r, cnt_nxt;
	logic [PW-1:0]                pwrt_r;
	logic [7:0]                   addr_lo_r;
	logic [ADDR_HI_W-1:0]         addr_hi_r;
	logic [7:0]                   data_lo_r;
	logic [DATA_HI_W-1:0]         data_hi_r;
	logic [7:0]                   ee_waddr_r, ee_wdata_r;
	logic [FL_AW-1:0]             fl_base_r;
	logic [BLK-1:0][WORD_W-1:0]   buf_r;
	logic                         last_r, done_r, rd_s1_r, squash_r;
	logic [7:0]                   rdata_r;
	logic [7:0]                   ee_rdata;
	logic [WORD_W-1:0]            fl_rdata;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	wire              wr_ctl     = ce & reg_we & (reg_addr == OFS_CONTROL);
	wire              wr_unl     = ce & reg_we & (reg_addr == OFS_UNLOCK);
	wire              wr_sts     = ce & reg_we & (reg_addr == OFS_STATUS);
	wire              idle       = op_r == OP_IDLE;
	wire              space_new  = reg_wdata[CTL_SPACE];
	wire [FL_AW-1:0]  fl_addr    = {addr_hi_r, addr_lo_r};
	wire              pwrt_done  = pwrt_r == PW'(PWRT_CYCLES);
	wire              cnt_zero   = cnt_r == '0;
	wire              last_word  = &addr_lo_r[BLK_BITS-1:0];

	// Protected segment is the low part of flash up to a limit
	wire [FL_AW-1:0]  prot_lim   = (block_protect_cfg == 2'h0) ? PROT_LIM_00 :
	                               (block_protect_cfg == 2'h1) ? PROT_LIM_01 :
	                               (block_protect_cfg == 2'h2) ? PROT_LIM_10 : PROT_LIM_11;
	wire              fl_prot    = fl_addr < prot_lim;

	wire              wr_req     = wr_ctl & reg_wdata[CTL_WR] & ~ctl_r.wr;
	wire              start_ok   = wr_req & (unl_r == UNL_KEY2) & reg_wdata[CTL_STORE_UNLOCK_ENABLE] & pwrt_done & idle & ~warm_rst;
	wire              ee_start   = start_ok & ~space_new;
	// refused flash start never holds the bit
	wire              fl_start   = start_ok & space_new & SELF_WRITE_EN & ~fl_prot;
	wire              rd_req     = wr_ctl & reg_wdata[CTL_RD] & idle;
	wire              ee_rd      = rd_req & ~space_new;
	wire              fl_rd      = rd_req & space_new;

	// Completion of each kind of cycle
	wire              ee_commit  = (op_r == OP_EE_WR) & cnt_zero & ~warm_rst;
	wire              fl_commit  = (op_r == OP_FL_STALL) & cnt_zero & ~warm_rst;
	wire              word_done  = (op_r == OP_FL_SETUP) & cnt_zero & ~last_r & ~warm_rst;
	wire              fin        = ee_commit | fl_commit | word_done;

	// ----------------------------------------------------------------
	// Unlock sequencer
	// ----------------------------------------------------------------
	// any cycle off the exact sequence drops back to idle
	assign unl_nxt = (wr_unl && reg_wdata == UNLOCK_KEY1) ? UNL_KEY1 :
	                 (wr_unl && reg_wdata == UNLOCK_KEY2 && unl_r == UNL_KEY1) ? UNL_KEY2 : UNL_IDLE;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			unl_r <= UNL_IDLE;
		end else if (ce) begin
			unl_r <= unl_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Control register next value
	// ----------------------------------------------------------------
	always_comb begin
		ctl_nxt = ctl_r;
		if (wr_ctl) begin
			ctl_nxt.space = reg_wdata[CTL_SPACE];
			ctl_nxt.store_unlock_enable  = reg_wdata[CTL_STORE_UNLOCK_ENABLE];
			ctl_nxt.abort = reg_wdata[CTL_ABORT];
		end
		// abort on reset, cleared on completion
		if (fin) begin
			ctl_nxt.abort = 1'b0;
		end
		if (warm_rst && !idle) begin
			ctl_nxt.abort = 1'b1;
		end
		if (fin || warm_rst) begin
			ctl_nxt.wr = 1'b0;
		end
		if (ee_start || fl_start) begin
			ctl_nxt.wr = 1'b1;
		end
		// read bit self-clears after one cycle
		ctl_nxt.rd = rd_req;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_r <= CTL_RESET;
		end else if (ce) begin
			ctl_r <= ctl_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Operation sequencer
	// ----------------------------------------------------------------
	// the enable is not looked at once a cycle runs
	always_comb begin
		op_nxt  = op_r;
		cnt_nxt = cnt_r;
		if (warm_rst) begin
			op_nxt = OP_IDLE;
		end else begin
			unique case (op_r)
				OP_IDLE: begin
					if (ee_start) begin
						op_nxt  = OP_EE_WR;
						cnt_nxt = CW'(EE_WRITE_CYCLES - 1);
					end else if (fl_start) begin
						op_nxt  = OP_FL_SETUP;
						cnt_nxt = CW'(SETUP_CYCLES - 1);
					end
				end
				OP_EE_WR, OP_FL_STALL: begin
					if (cnt_zero) begin
						op_nxt = OP_IDLE;
					end else begin
						cnt_nxt = cnt_r - 1'b1;
					end
				end
				OP_FL_SETUP: begin
					if (cnt_zero) begin
						// stall only for the final word
						op_nxt  = last_r ? OP_FL_STALL : OP_IDLE;
						cnt_nxt = CW'(ERASE_CYCLES + FLASH_PROG_CYCLES - 1);
					end else begin
						cnt_nxt = cnt_r - 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			op_r  <= OP_IDLE;
			cnt_r <= '0;
		end else if (ce) begin
			op_r  <= op_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Power-up timer, counts once after reset release
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pwrt_r <= '0;
		end else if (ce && !pwrt_done) begin
			pwrt_r <= pwrt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Address and data registers
	// ----------------------------------------------------------------
	// read data replaces the held value, else it stays
	wire [7:0]           data_lo_nxt = (ce && reg_we && reg_addr == OFS_DATA_LO) ? reg_wdata :
	                                   ee_rd ? ee_rdata : fl_rd ? fl_rdata[7:0] : data_lo_r;
	wire [DATA_HI_W-1:0] data_hi_nxt = (ce && reg_we && reg_addr == OFS_DATA_HI) ? reg_wdata[DATA_HI_W-1:0] :
	                                   fl_rd ? fl_rdata[WORD_W-1:8] : data_hi_r;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			addr_lo_r <= BYTE_RESET;
			addr_hi_r <= '0;
			data_lo_r <= BYTE_RESET;
			data_hi_r <= '0;
		end else if (ce) begin
			if (reg_we && reg_addr == OFS_ADDR_LO) begin
				addr_lo_r <= reg_wdata;
			end
			if (reg_we && reg_addr == OFS_ADDR_HI) begin
				addr_hi_r <= reg_wdata[ADDR_HI_W-1:0];
			end
			data_lo_r <= data_lo_nxt;
			data_hi_r <= data_hi_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Write latches and block buffer
	// ----------------------------------------------------------------
	// Latched at start so later register writes cannot corrupt a cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ee_waddr_r <= BYTE_RESET;
			ee_wdata_r <= BYTE_RESET;
			fl_base_r  <= '0;
			last_r     <= 1'b0;
			buf_r      <= '0;
		end else if (ce) begin
			if (ee_start) begin
				ee_waddr_r <= addr_lo_r;
				ee_wdata_r <= data_lo_r;
			end
			// buffer entry picked by low address bits
			if (fl_start) begin
				fl_base_r                      <= fl_addr;
				last_r                         <= last_word;
				buf_r[addr_lo_r[BLK_BITS-1:0]] <= {data_hi_r, data_lo_r};
			end
		end
	end

	// ----------------------------------------------------------------
	// Done flag and squash pipeline
	// ----------------------------------------------------------------
	// set beats a same-cycle software clear
	wire done_nxt = fin | (wr_sts ? reg_wdata[STS_DONE] : done_r);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			done_r   <= 1'b0;
			rd_s1_r  <= 1'b0;
			squash_r <= 1'b0;
		end else if (ce) begin
			done_r   <= done_nxt;
			// second instruction after the read is dropped
			rd_s1_r  <= fl_rd;
			squash_r <= rd_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	wire [7:0] ctl_rd = {ctl_r.space, 3'h0, ctl_r.abort, ctl_r.store_unlock_enable, ctl_r.wr, ctl_r.rd};
	wire [7:0] rd_mux = (reg_addr == OFS_CONTROL) ? ctl_rd :
	                    (reg_addr == OFS_ADDR_LO) ? addr_lo_r :
	                    (reg_addr == OFS_ADDR_HI) ? {3'h0, addr_hi_r} :
	                    (reg_addr == OFS_DATA_LO) ? data_lo_r :
	                    (reg_addr == OFS_DATA_HI) ? {2'h0, data_hi_r} :
	                    (reg_addr == OFS_STATUS)  ? {7'h00, done_r} : 8'h00;

	// Data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 8'h00;
		end else if (ce) begin
			rdata_r <= reg_re ? rd_mux : 8'h00;
		end
	end

	// stall ends after program, CPU resumes
	assign cpu_stall    = op_r == OP_FL_STALL;
	assign insn_squash  = squash_r;
	assign nv_done_flag = done_r;
	assign reg_rdata    = rdata_r;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	nv_array #(
		.EE_AW    (8),
		.FL_BITS  (FL_AW),
		.BLK_BITS (BLK_BITS)
	) u_array (
		.mclk      (mclk),
		.ce        (ce),
		.ee_addr   (addr_lo_r),
		.ee_rdata  (ee_rdata),
		.ee_we     (ee_commit),
		.ee_waddr  (ee_waddr_r),
		.ee_wdata  (ee_wdata_r),
		.fl_addr   (fl_addr),
		.fl_rdata  (fl_rdata),
		.fl_commit (fl_commit),
		.fl_base   (fl_base_r),
		.fl_buf    (buf_r)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n || !ce);

	sequence s_set_wr;
		reg_we && reg_addr == OFS_CONTROL && reg_wdata[CTL_WR] && !ctl_r.wr;
	endsequence
	sequence s_two_bubble;
		!cpu_stall ##1 !cpu_stall ##1 cpu_stall;
	endsequence

	property p_unlock_needed;
		$rose(ctl_r.wr) |-> $past(unl_r == UNL_KEY2) && $past(reg_wdata[CTL_STORE_UNLOCK_ENABLE]);
	endproperty
	a_unlock_needed: assert property (p_unlock_needed) else $error("start without unlock");
	property p_store_unlock_enable_gate;
		s_set_wr and (!reg_wdata[CTL_STORE_UNLOCK_ENABLE]) |=> !ctl_r.wr;
	endproperty
	a_store_unlock_enable_gate: assert property (p_store_unlock_enable_gate) else $error("start taken with enable clear");
	property p_store_unlock_enable_kept;
		!(reg_we && reg_addr == OFS_CONTROL) |=> $stable(ctl_r.store_unlock_enable);
	endproperty
	a_store_unlock_enable_kept: assert property (p_store_unlock_enable_kept) else $error("enable changed by hardware");
	property p_ee_done;
		op_r == OP_EE_WR && cnt_zero && !warm_rst |=> !ctl_r.wr && done_r && !ctl_r.abort;
	endproperty
	a_ee_done: assert property (p_ee_done) else $error("completion not flagged");
	property p_squash;
		fl_rd |=> !insn_squash ##1 insn_squash ##1 !insn_squash;
	endproperty
	a_squash: assert property (p_squash) else $error("wrong instruction dropped");
	property p_ee_read;
		ee_rd |=> data_lo_r == $past(ee_rdata);
	endproperty
	a_ee_read: assert property (p_ee_read) else $error("read data late");
	property p_protect;
		s_set_wr and (reg_wdata[CTL_SPACE] && fl_prot) |=> !ctl_r.wr && op_r == OP_IDLE;
	endproperty
	a_protect: assert property (p_protect) else $error("protected flash start held");
	property p_stall;
		fl_start && last_word |=> s_two_bubble;
	endproperty
	a_stall: assert property (p_stall) else $error("stall timing wrong");
	property p_set_only;
		ctl_r.wr && !fin && !warm_rst && reg_we && reg_addr == OFS_CONTROL && !reg_wdata[CTL_WR] |=> ctl_r.wr;
	endproperty
	a_set_only: assert property (p_set_only) else $error("software cleared start bit");
	property p_abort;
		warm_rst && op_r != OP_IDLE |=> ctl_r.abort && !ctl_r.wr && op_r == OP_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("abort not flagged");
	property p_pwrt;
		!pwrt_done |=> !ctl_r.wr;
	endproperty
	a_pwrt: assert property (p_pwrt) else $error("write during power-up timer");

endmodule

// ### nv_pkg.sv
// Constants, types and register map of the self-programming nonvolatile controller
package nv_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the plain register port
	// ----------------------------------------------------------------
	localparam int         REG_AW       = 3;
	localparam logic [2:0] OFS_CONTROL  = 3'h0;
	localparam logic [2:0] OFS_UNLOCK   = 3'h1;
	localparam logic [2:0] OFS_ADDR_LO  = 3'h2;
	localparam logic [2:0] OFS_ADDR_HI  = 3'h3;
	localparam logic [2:0] OFS_DATA_LO  = 3'h4;
	localparam logic [2:0] OFS_DATA_HI  = 3'h5;
	localparam logic [2:0] OFS_STATUS   = 3'h6;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int CTL_RD      = 0;
	localparam int CTL_WR      = 1;
	localparam int CTL_STORE_UNLOCK_ENABLE    = 2;
	localparam int CTL_ABORT   = 3;
	localparam int CTL_SPACE   = 7;
	localparam int STS_DONE    = 0;
	localparam int ADDR_HI_W   = 5;
	localparam int DATA_HI_W   = 6;
	localparam int FL_AW       = 13;
	localparam int WORD_W      = 14;
	localparam int ERASE_BITS  = 4;

	// ----------------------------------------------------------------
	// Key values, reset values and protection limits
	// ----------------------------------------------------------------
	localparam logic [7:0]        UNLOCK_KEY1  = 8'h55;
	localparam logic [7:0]        UNLOCK_KEY2  = 8'haa;
	localparam logic [7:0]        BYTE_RESET   = 8'h00;
	localparam logic [WORD_W-1:0] ERASED_WORD  = 14'h3fff;
	localparam logic [FL_AW-1:0]  PROT_LIM_00  = 13'h1000;
	localparam logic [FL_AW-1:0]  PROT_LIM_01  = 13'h0800;
	localparam logic [FL_AW-1:0]  PROT_LIM_10  = 13'h0100;
	localparam logic [FL_AW-1:0]  PROT_LIM_11  = 13'h0000;

	// ----------------------------------------------------------------
	// Timing, as printed and as cycles of the 200 MHz clock
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 200;
	localparam int ERASE_TIME_US    = 4000;
	localparam int PWRT_TIME_US     = 64000;
	localparam int ERASE_CYCLES_DEF = ERASE_TIME_US * CLK_MHZ;
	localparam int PWRT_CYCLES_DEF  = PWRT_TIME_US * CLK_MHZ;
	localparam int SETUP_CYCLES     = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic space;
		logic abort;
		logic store_unlock_enable;
		logic wr;
		logic rd;
	} ctl_t;

	localparam ctl_t CTL_RESET = '0;

	typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_KEY2} unl_t;
	typedef enum logic [1:0] {OP_IDLE, OP_EE_WR, OP_FL_SETUP, OP_FL_STALL} op_t;

endpackage

// ### test_self_program_nv_controller.sv
// Self-checking bench for the self-programming nonvolatile controller
`timescale 1ns/100ps
module test_self_program_nv_controller import nv_pkg::*;;
	localparam int ERASE = 10;
	localparam int PROG  = 5;
	localparam int EEW   = 5;
	localparam int PWRT  = 20;

	logic              mclk;
	logic              reset_n;
	logic              ce;
	logic              warm_rst;
	logic [1:0]        block_protect_cfg;
	logic [REG_AW-1:0] reg_addr;
	logic [7:0]        reg_wdata;
	logic              reg_we;
	logic              reg_re;
	logic [7:0]        reg_rdata;
	logic              cpu_stall;
	logic              insn_squash;
	logic              nv_done_flag;
	logic [7:0]        exp_q[$];
	logic              pend;
	logic [13:0]       wd[8];
	logic [31:0]       r;
	logic [7:0]        a;
	logic [7:0]        d;
	logic [7:0]        base;
	int                n_fail;
	int                n_checks;

	// ----------------------------------------------------------------
	// Clock and instance
	// ----------------------------------------------------------------
	// Short counts keep the run small
	always #2.5 mclk = ~mclk;
	nv_ctrl #(.ERASE_CYCLES(ERASE), .PWRT_CYCLES(PWRT), .EE_WRITE_CYCLES(EEW), .FLASH_PROG_CYCLES(PROG)) DUT (
		.mclk(mclk), .reset_n(reset_n), .ce(ce), .warm_rst(warm_rst), .block_protect_cfg(block_protect_cfg),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.cpu_stall(cpu_stall), .insn_squash(insn_squash), .nv_done_flag(nv_done_flag));

	// ----------------------------------------------------------------
	// Checks and bus tasks
	// ----------------------------------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		if (n_fail == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Strobes stay up until idle or the other access task lowers them, so no signal is set twice per step
	task wr(input logic [2:0] ad, input logic [7:0] v);
		reg_we <= 1'b1;
		reg_re <= 1'b0;
		reg_addr <= ad;
		reg_wdata <= v;
		@(posedge mclk);
	endtask
	task rd(input logic [2:0] ad, input logic [7:0] e);
		reg_re <= 1'b1;
		reg_we <= 1'b0;
		reg_addr <= ad;
		exp_q.push_back(e);
		@(posedge mclk);
	endtask
	task idle(input int n);
		reg_we <= 1'b0;
		reg_re <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask
	task ul(input logic [7:0] c);
		wr(OFS_UNLOCK, UNLOCK_KEY1);
		wr(OFS_UNLOCK, UNLOCK_KEY2);
		wr(OFS_CONTROL, c);
	endtask
	// Stall must stay low in both setup cycles, then span erase plus program for the last word only
	task fl_word(input logic [7:0] lo, input logic [13:0] w, input bit last);
		int n;
		n = 0;
		wr(OFS_ADDR_LO, lo);
		wr(OFS_DATA_LO, w[7:0]);
		wr(OFS_DATA_HI, {2'h0, w[13:8]});
		ul(8'h86);
		idle(0);
		#1 chk({7'h00, cpu_stall}, 8'h00);
		@(posedge mclk);
		#1 chk({7'h00, cpu_stall}, 8'h00);
		@(posedge mclk);
		#1;
		while (cpu_stall === 1'b1 && n < 100) begin
			n++;
			@(posedge mclk);
			#1;
		end
		chk(8'(n), last ? 8'(ERASE + PROG) : 8'h00);
		// Back on a rising edge before the next bus step
		@(posedge mclk);
	endtask
	task fl_rd(input logic [7:0] lo, input logic [13:0] w);
		wr(OFS_ADDR_LO, lo);
		wr(OFS_CONTROL, 8'h81);
		idle(1);
		#1 chk({7'h00, insn_squash}, 8'h01);
		@(posedge mclk);
		#1 chk({7'h00, insn_squash}, 8'h00);
		// Bus moves again only on an edge
		@(posedge mclk);
		rd(OFS_DATA_LO, w[7:0]);
		rd(OFS_DATA_HI, {2'h0, w[13:8]});
		rd(OFS_DATA_LO, w[7:0]);
	endtask

	// ----------------------------------------------------------------
	// Result monitor
	// ----------------------------------------------------------------
	// Read data stands only in the cycle after the strobe
	always @(posedge mclk) pend <= reg_re;
	always @(negedge mclk) begin
		if (pend === 1'b1) begin
			if (exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
			else begin
				// A read with no note is a mismatch, never a silent pass
				n_fail++;
				$display("wrong value at %0t: got %h expected %h", $time, reg_rdata, 8'h00);
			end
		end
	end
	// Hang guard, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		test_done;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0; reset_n = 1'b0; ce = 1'b1; warm_rst = 1'b0; block_protect_cfg = 2'b11;
		reg_addr = '0; reg_wdata = '0; reg_we = 1'b0; reg_re = 1'b0;
		n_fail = 0; n_checks = 0;
		r = $urandom(32'hd570a274);
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		// Reset values, unmapped and write-only reads, power-up lockout
		rd(OFS_CONTROL, 8'h00);
		rd(OFS_STATUS, 8'h00);
		rd(OFS_UNLOCK, 8'h00);
		rd(3'h7, 8'h00);
		ul(8'h06);
		rd(OFS_CONTROL, 8'h04);
		idle(PWRT + 5);
		r = $urandom;
		a = r[7:0];
		d = r[15:8];
		// Broken unlock sequences never start a write
		for (int k = 0; k < 3; k++) begin
			case (k)
				0: begin wr(OFS_UNLOCK, UNLOCK_KEY1); idle(1); wr(OFS_UNLOCK, UNLOCK_KEY2); end
				1: begin wr(OFS_UNLOCK, UNLOCK_KEY2); wr(OFS_UNLOCK, UNLOCK_KEY1); end
				default: begin wr(OFS_UNLOCK, UNLOCK_KEY1); wr(OFS_UNLOCK, UNLOCK_KEY2); wr(OFS_ADDR_LO, a); end
			endcase
			wr(OFS_CONTROL, 8'h06);
			rd(OFS_CONTROL, 8'h04);
		end
		wr(OFS_CONTROL, 8'h00);
		ul(8'h02);
		rd(OFS_CONTROL, 8'h00);
		// Good byte write, enable dropped mid-cycle
		// address and data before unlock
		wr(OFS_ADDR_LO, a);
		wr(OFS_DATA_LO, d);
		ul(8'h06);
		rd(OFS_CONTROL, 8'h06);
		wr(OFS_CONTROL, 8'h00);
		idle(EEW + 5);
		chk({7'h00, nv_done_flag}, 8'h01);
		rd(OFS_CONTROL, 8'h00);
		idle(5);
		rd(OFS_STATUS, 8'h01);
		wr(OFS_STATUS, 8'h00);
		rd(OFS_STATUS, 8'h00);
		// Aborted write leaves old byte and sets the abort flag
		wr(OFS_DATA_LO, ~d);
		ul(8'h06);
		warm_rst <= 1'b1;
		idle(1);
		warm_rst <= 1'b0;
		rd(OFS_CONTROL, 8'h0c);
		idle(EEW + 5);
		rd(OFS_STATUS, 8'h00);
		wr(OFS_CONTROL, 8'h05);
		rd(OFS_DATA_LO, d);
		// Clock enable low freezes the registers, so the write is lost
		ce <= 1'b0;
		wr(OFS_ADDR_LO, ~a);
		ce <= 1'b1;
		rd(OFS_ADDR_LO, a);
		ul(8'h06);
		idle(EEW + 5);
		rd(OFS_CONTROL, 8'h04);
		// Flash block: eight loads, commit on the last, upper half erased
		r = $urandom;
		base = {r[3:0], 4'h0};
		for (int i = 0; i < 8; i++) wd[i] = 14'($urandom);
		wr(OFS_ADDR_HI, {3'h0, r[8:4]});
		for (int i = 0; i < 8; i++) fl_word(base | 8'(i), wd[i], i == 7);
		for (int i = 0; i < 16; i++) fl_rd(base | 8'(i), i < 8 ? wd[i] : ERASED_WORD);
		// Protected segment refuses the start bit in every limited setting;
		// a last-word address would stall if the start were taken
		for (int c = 0; c < 3; c++) begin
			block_protect_cfg <= 2'(c);
			wr(OFS_ADDR_HI, 8'h00);
			wr(OFS_ADDR_LO, 8'h17);
			ul(8'h86);
			rd(OFS_CONTROL, 8'h84);
			idle(3);
			chk({7'h00, cpu_stall}, 8'h00);
		end
		idle(3);
		test_done;
	end
endmodule
